// ==== hw/hfc_pkg.sv ====
// Constants and carrier types for the flash erase sequencer controller
package hfc_pkg;
  localparam int CLK_NS = 10;
  localparam int T_WP_NS = 50;
  localparam int T_ACC_NS = 150;
  localparam int T_WIN_US = 80;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WIN_CYC_DEF = (T_WIN_US * 1000) / CLK_NS;
  localparam logic [7:0] WP_CNT = 8'(WP_CYC - 1);
  localparam logic [7:0] ACC_CNT = 8'(ACC_CYC - 1);

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SECT = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam int CTRL_CHIP = 0;
  localparam int CTRL_SECT = 1;
  localparam int CTRL_RST = 2;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_LOCK = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [16:0] ADDR_UNLOCK1 = 17'h05555;
  localparam logic [16:0] ADDR_UNLOCK2 = 17'h02aaa;
  localparam logic [7:0] CODE_UNLOCK1 = 8'haa;
  localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0] CODE_SETUP = 8'h80;
  localparam logic [7:0] CODE_CHIP = 8'h10;
  localparam logic [7:0] CODE_SECT = 8'h30;
  localparam logic [7:0] CODE_RESET = 8'hf0;
  localparam int SECT_LSB = 14;
  localparam logic [2:0] STEP_RST_LAST = 3'h2;
  localparam logic [2:0] STEP_LAST = 3'h5;

  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int TIME_LIMIT_FLAG = 5;
  localparam int PHASE_FLAG = 4;
  localparam int ERASE_TIMER_FLAG = 3;

  typedef enum logic [1:0] {CYC_IDLE = 2'b00, CYC_SETUP = 2'b01, CYC_STROBE = 2'b11, CYC_HOLD = 2'b10} hfc_cyc_type;
  typedef enum logic [2:0] {SEQ_IDLE = 3'b000, SEQ_CMD = 3'b001, SEQ_POLL = 3'b011, SEQ_RECHECK = 3'b010}
    hfc_seq_type;
  typedef enum logic [1:0] {KIND_CHIP = 2'b00, KIND_SECT = 2'b01, KIND_RST = 2'b10} hfc_kind_type;

  typedef struct packed {
    logic valid;
    logic wr;
    logic [16:0] addr;
    logic [7:0] data;
  } hfc_req_type;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [16:0] addr;
    logic [7:0] dq_o;
    logic dq_oe;
  } hfc_pins_type;

  localparam hfc_pins_type PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 17'h00000, dq_o: 8'h00,
    dq_oe: 1'b0};
endpackage

// ==== hw/hfc_strobe_engine.sv ====
// One flash bus cycle (write or read) on the strobe pins
`timescale 1ns/10ps
`default_nettype none
module hfc_strobe_engine import hfc_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire hfc_req_type i_req,
  output logic o_ready,
  output logic o_done,
  output logic [7:0] o_rdata,
  input wire logic [7:0] i_dq,
  output hfc_pins_type o_pins
);
  typedef struct packed {
    hfc_cyc_type st;
    logic [7:0] cnt;
    logic wr;
    logic [7:0] rdata;
    hfc_pins_type pins;
  } hfc_eng_type;
  localparam hfc_eng_type ENG_RST = '{st: CYC_IDLE, cnt: 8'h00, wr: 1'b0, rdata: 8'h00, pins: PINS_IDLE};

  hfc_eng_type r_reg;
  hfc_eng_type r_next;

  always_comb begin
    r_next = r_reg;
    case (r_reg.st)
      CYC_IDLE: begin
        if (i_req.valid) begin
          r_next.st = CYC_SETUP;
          r_next.wr = i_req.wr;
          r_next.pins.ce_n = 1'b0;
          r_next.pins.oe_n = i_req.wr; // [RULE_15]
          r_next.pins.addr = i_req.addr;
          r_next.pins.dq_o = i_req.data;
          r_next.pins.dq_oe = i_req.wr;
          r_next.cnt = ACC_CNT;
        end
      end
      CYC_SETUP: begin
        if (r_reg.wr) begin
          r_next.st = CYC_STROBE;
          r_next.pins.we_n = 1'b0; // [RULE_15]
          r_next.cnt = WP_CNT;
        end else if (r_reg.cnt == 8'h00) begin
          r_next.rdata = i_dq;
          r_next.pins.oe_n = 1'b1;
          r_next.st = CYC_HOLD;
        end else begin
          r_next.cnt = r_reg.cnt - 8'h01;
        end
      end
      CYC_STROBE: begin
        if (r_reg.cnt == 8'h00) begin
          r_next.pins.we_n = 1'b1;
          r_next.st = CYC_HOLD;
        end else begin
          r_next.cnt = r_reg.cnt - 8'h01;
        end
      end
      CYC_HOLD: begin
        r_next.pins = PINS_IDLE;
        r_next.st = CYC_IDLE;
      end
      default: r_next = ENG_RST;
    endcase
  end

  // Strobes idle high from reset, so no write edge follows power-up
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      r_reg <= ENG_RST; // [RULE_13]
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_ready = (r_reg.st == CYC_IDLE);
  assign o_done = (r_reg.st == CYC_HOLD);
  assign o_rdata = r_reg.rdata;
  assign o_pins = r_reg.pins;

  chk_write_strobe_legal: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE_15]
    !o_pins.we_n |-> (!o_pins.ce_n && o_pins.oe_n && o_pins.dq_oe))
    else $error("write strobe low without chip select or with output enable");

  chk_write_pulse_len: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE_15]
    $fell(o_pins.we_n) |-> !o_pins.we_n[*5] ##1 (o_pins.we_n && !o_pins.ce_n))
    else $error("write strobe pulse has wrong length or chip select released early");
endmodule
`default_nettype wire

// ==== hw/hfc_erase_ctrl.sv ====
// Erase sequencer controller: AXI4-Lite registers, command strings, status polling
`timescale 1ns/10ps
`default_nettype none
//
// Function
// [RULE_01] Chip erase is six writes: unlock, setup, unlock, code
// [RULE_02] Device pre-programs zeros, then erases all sectors
// [RULE_03] Chip erase ends when polling bit reads one
// [RULE_04] Sector address on falling, code on rising strobe
// [RULE_05] Device erases after timeout from last command
// [RULE_06] Extra sector writes restart the device timer
// [RULE_07] Late sector command rejected, queued erase proceeds
// [RULE_08] Other command in window aborts to read mode
// [RULE_09] Host queues sector writes without interruption
// [RULE_10] Only selected sectors erased, any number, any order
// [RULE_11] Host polls at address inside an erased sector
// [RULE_12] Power-up leaves device in read mode
// [RULE_13] No command accepted on power-up write edge
// [RULE_14] Supply lockout disables commands, returns to read
// [RULE_15] Write needs chip select, write low, output high
// [RULE_16] Program polling bit reads complement until done
// [RULE_17] Erase polling bit reads zero until done
// [RULE_18] Polling active only during embedded operations
// [RULE_19] Toggle bit inverts each read while busy
// [RULE_20] Status flags report erase timer and phase
// [RULE_21] Time-limit flag marks a failed operation
// [RULE_22] Host recovers from failure with reset command
// [RULE_23] Erase timer flag zero while window open
// [RULE_24] Three top address bits select the sector
// [RULE_25] No new command before previous completes or fails
module hfc_erase_ctrl import hfc_pkg::*; #(
  parameter int unsigned WIN_CYC = WIN_CYC_DEF
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_lockout,
  output logic o_flash_ce_n,
  output logic o_flash_oe_n,
  output logic o_flash_we_n,
  output logic [16:0] o_flash_addr,
  output logic [7:0] o_flash_dq,
  output logic o_flash_dq_oe,
  input wire logic [7:0] i_flash_dq
);
  typedef struct packed {
    hfc_seq_type st;
    hfc_kind_type kind;
    logic [2:0] step;
    logic [2:0] sect;
    logic [2:0] poll_sect;
    logic [7:0] pend;
    logic [7:0] mask;
    logic done;
    logic fail;
    logic [7:0] stat;
    hfc_req_type req;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } hfc_top_type;

  hfc_top_type r_reg;
  hfc_top_type r_next;
  logic eng_done;
  logic eng_ready;
  logic [7:0] eng_rdata;
  hfc_pins_type pins;

  function automatic logic [2:0] lowest_set(input logic [7:0] m);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  function automatic hfc_req_type cmd_step(input hfc_kind_type k, input logic [2:0] s, input logic [2:0] sect);
    hfc_req_type q;
    q = '{valid: 1'b1, wr: 1'b1, addr: ADDR_UNLOCK1, data: CODE_UNLOCK1};
    case (s)
      3'h1, 3'h4: begin
        q.addr = ADDR_UNLOCK2;
        q.data = CODE_UNLOCK2;
      end
      3'h2: q.data = (k == KIND_RST) ? CODE_RESET : CODE_SETUP;
      3'h5: begin
        if (k == KIND_SECT) begin
          q.addr = {sect, 14'h0000}; // [RULE_24]
          q.data = CODE_SECT; // [RULE_04]
        end else begin
          q.data = CODE_CHIP; // [RULE_01]
        end
      end
      default: q.data = CODE_UNLOCK1;
    endcase
    return q;
  endfunction

  hfc_strobe_engine u_eng (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_req(r_reg.req),
    .o_ready(eng_ready),
    .o_done(eng_done),
    .o_rdata(eng_rdata),
    .i_dq(i_flash_dq),
    .o_pins(pins)
  );

  always_comb begin
    r_next = r_reg;
    if (i_awvalid && o_awready) begin
      r_next.aw_have = 1'b1;
      r_next.awaddr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      r_next.w_have = 1'b1;
      r_next.wdata = i_wdata;
      // Lane enable kept with the data; the master may drop it once taken
      r_next.wstrb0 = i_wstrb[0];
    end
    if (r_reg.bvalid && i_bready) begin
      r_next.bvalid = 1'b0;
    end
    if (r_reg.rvalid && i_rready) begin
      r_next.rvalid = 1'b0;
    end
    if (i_arvalid && o_arready) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = RESP_OKAY;
      case (i_araddr)
        REG_SECT: r_next.rdata = {24'h000000, r_reg.mask};
        REG_STAT: r_next.rdata = {16'h0000, r_reg.stat, 4'h0, i_lockout, r_reg.fail, r_reg.done,
          r_reg.st != SEQ_IDLE};
        REG_CTRL: r_next.rdata = 32'h00000000;
        default: begin
          r_next.rdata = 32'h00000000;
          r_next.rresp = RESP_SLVERR;
        end
      endcase
    end
    // Write acts once both address and data are held
    if (r_reg.aw_have && r_reg.w_have) begin
      r_next.aw_have = 1'b0;
      r_next.w_have = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = RESP_OKAY;
      case (r_reg.awaddr)
        REG_SECT: if (r_reg.wstrb0) begin
          r_next.mask = r_reg.wdata[7:0];
        end
        REG_STAT: if (r_reg.wstrb0) begin
          r_next.done = r_reg.done & ~r_reg.wdata[ST_DONE];
          r_next.fail = r_reg.fail & ~r_reg.wdata[ST_FAIL];
        end
        REG_CTRL: if (r_reg.wstrb0 && r_reg.st == SEQ_IDLE && !i_lockout) begin // [RULE_25]
          r_next.step = 3'h0;
          r_next.done = 1'b0;
          r_next.fail = 1'b0;
          r_next.poll_sect = 3'h0;
          if (r_reg.wdata[CTRL_CHIP]) begin
            r_next.kind = KIND_CHIP;
            r_next.st = SEQ_CMD;
          end else if (r_reg.wdata[CTRL_SECT] && r_reg.mask != 8'h00) begin
            r_next.kind = KIND_SECT;
            r_next.pend = r_reg.mask; // [RULE_10]
            r_next.sect = lowest_set(r_reg.mask);
            r_next.poll_sect = lowest_set(r_reg.mask); // [RULE_11]
            r_next.st = SEQ_CMD;
          end else if (r_reg.wdata[CTRL_RST]) begin
            r_next.kind = KIND_RST;
            r_next.st = SEQ_CMD;
          end
        end
        default: r_next.bresp = RESP_SLVERR;
      endcase
    end
    case (r_reg.st)
      SEQ_IDLE: r_next.req.valid = 1'b0;
      SEQ_CMD: begin
        // Request waits for an idle engine; a cycle left over from a lockout abort still raises eng_done and counts as this step
        if (!r_reg.req.valid && eng_ready) begin
          r_next.req = cmd_step(r_reg.kind, r_reg.step, r_reg.sect);
        end else if (eng_done) begin
          r_next.req.valid = 1'b0;
          if (r_reg.kind == KIND_RST && r_reg.step == STEP_RST_LAST) begin
            r_next.st = SEQ_IDLE; // [RULE_22]
            r_next.done = !r_reg.fail;
          end else if (r_reg.step == STEP_LAST && r_reg.kind == KIND_SECT) begin
            // Next sector follows at once to stay inside the window
            r_next.pend[r_reg.sect] = 1'b0; // [RULE_09]
            r_next.sect = lowest_set(r_next.pend); // [RULE_06]
            if (r_next.pend == 8'h00) begin
              r_next.st = SEQ_POLL;
            end
          end else if (r_reg.step == STEP_LAST) begin
            r_next.st = SEQ_POLL; // [RULE_03]
          end else begin
            r_next.step = r_reg.step + 3'h1;
          end
        end
      end
      SEQ_POLL, SEQ_RECHECK: begin
        if (!r_reg.req.valid && eng_ready) begin
          r_next.req = '{valid: 1'b1, wr: 1'b0, addr: {r_reg.poll_sect, 14'h0000}, data: 8'h00}; // [RULE_11]
        end else if (eng_done) begin
          r_next.req.valid = 1'b0;
          r_next.stat = eng_rdata; // [RULE_20]
          if (eng_rdata[POLL_BIT]) begin
            r_next.st = SEQ_IDLE; // [RULE_17]
            r_next.done = 1'b1;
          end else if (r_reg.st == SEQ_RECHECK) begin
            // Poll bit may flip with the limit flag, hence the second read
            r_next.fail = 1'b1; // [RULE_21]
            r_next.kind = KIND_RST;
            r_next.step = 3'h0;
            r_next.st = SEQ_CMD; // [RULE_22]
          end else if (eng_rdata[TIME_LIMIT_FLAG]) begin
            r_next.st = SEQ_RECHECK; // [RULE_21]
          end
        end
      end
      default: r_next.st = SEQ_IDLE;
    endcase
    if (i_lockout) begin
      r_next.st = SEQ_IDLE; // [RULE_14]
      r_next.req.valid = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      r_reg <= '0; // [RULE_12]
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_awready = !r_reg.aw_have && !r_reg.bvalid;
  assign o_wready = !r_reg.w_have && !r_reg.bvalid;
  assign o_arready = !r_reg.rvalid;
  assign o_bvalid = r_reg.bvalid;
  assign o_bresp = r_reg.bresp;
  assign o_rvalid = r_reg.rvalid;
  assign o_rdata = r_reg.rdata;
  assign o_rresp = r_reg.rresp;
  assign o_flash_ce_n = pins.ce_n;
  assign o_flash_oe_n = pins.oe_n;
  assign o_flash_we_n = pins.we_n;
  assign o_flash_addr = pins.addr;
  assign o_flash_dq = pins.dq_o;
  assign o_flash_dq_oe = pins.dq_oe;

  // Cycles since the last sector code write, for the window check
  logic [15:0] gap_cnt;
  logic gap_run;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || (eng_done && r_reg.req.data == CODE_SECT && r_reg.st == SEQ_CMD)) begin
      gap_cnt <= 16'h0000;
      gap_run <= !i_rst;
    end else if (r_reg.st != SEQ_CMD) begin
      gap_run <= 1'b0;
    end else if (gap_run) begin
      gap_cnt <= gap_cnt + 16'h0001;
    end
  end

  sequence s_last_write;
    r_reg.st == SEQ_CMD && r_reg.step == STEP_LAST && eng_done && !i_lockout;
  endsequence

  chk_chip_code_last: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE_01]
    (r_reg.st == SEQ_CMD && r_reg.kind == KIND_CHIP && r_reg.step == STEP_LAST && r_reg.req.valid) |->
      (r_reg.req.addr == ADDR_UNLOCK1 && r_reg.req.data == CODE_CHIP))
    else $error("chip erase last write has wrong code");
  chk_sector_code_addr: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE_04]
    (r_reg.kind == KIND_SECT && r_reg.step == STEP_LAST && r_reg.req.valid && r_reg.st == SEQ_CMD) |->
      (r_reg.req.data == CODE_SECT && r_reg.req.addr[16:SECT_LSB] == r_reg.sect))
    else $error("sector erase write has wrong code or sector");
  chk_poll_after_chip: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE_03]
    (s_last_write ##0 (r_reg.kind == KIND_CHIP)) |=> r_reg.st == SEQ_POLL ##1 (r_reg.req.valid && !r_reg.req.wr))
    else $error("no polling read after chip erase string");
  chk_poll_in_sector: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE_11]
    (r_reg.st == SEQ_POLL && r_reg.kind == KIND_SECT && r_reg.req.valid) |->
      (r_reg.req.addr[16:SECT_LSB] == r_reg.poll_sect && r_reg.mask[r_reg.poll_sect]))
    else $error("polling read outside an erased sector");
  chk_sector_gap: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE_06]
    (gap_run && r_reg.kind == KIND_SECT) |-> gap_cnt < 16'(WIN_CYC))
    else $error("sector writes spaced beyond accumulation window");
  chk_busy_refuse: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE_25]
    (r_reg.st != SEQ_IDLE && r_reg.st != SEQ_RECHECK && $stable(r_reg.st)) |=> $stable(r_reg.kind) || i_lockout
      || $past(r_reg.st) == SEQ_RECHECK || r_reg.fail)
    else $error("new command taken while busy");
  chk_lockout_abort: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE_14]
    i_lockout |=> (r_reg.st == SEQ_IDLE && !r_reg.req.valid))
    else $error("sequence continues under supply lockout");
  chk_fail_resets: assert property (@(posedge i_clk_sys) disable iff (i_rst) // [RULE_22]
    $rose(r_reg.fail) |-> (r_reg.kind == KIND_RST && r_reg.st == SEQ_CMD && r_reg.step == 3'h0) || i_lockout)
    else $error("time-limit failure not followed by reset string");
endmodule
`default_nettype wire

// ==== tb/hfc_flash_model.sv ====
// Behavioural flash die answering the erase sequencer's strobes
`timescale 1ns/10ps
`default_nettype none
module hfc_flash_model import hfc_pkg::*; #(
  parameter int WIN = 8000,
  parameter int PRG = 200,
  parameter int ERS = 300
) (
  input wire logic i_clk_sys,
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [16:0] i_addr,
  input wire logic [7:0] i_dq,
  input wire logic i_lockout,
  input wire logic i_fail,
  output logic [7:0] o_dq,
  output logic [7:0] o_erased
);
  typedef enum logic [2:0] {F_RD, F_WIN, F_PRG, F_ERS, F_FAIL} hfc_fst_type;
  hfc_fst_type st = F_RD;
  logic [2:0] step = 3'h0;
  logic [7:0] sel = 8'h00;
  logic [7:0] last = 8'h00;
  logic [7:0] val;
  logic [16:0] a_l = 17'h0;
  logic [22:0] cmd;
  logic wep = 1'b1;
  logic oep = 1'b1;
  logic tog = 1'b0;
  logic pu_inh = 1'b0;
  logic wr_ok;
  int cnt = 0;
  initial o_erased = 8'h00;
  initial #1 pu_inh = (i_we_n === 1'b0 && i_ce_n === 1'b0 && i_oe_n === 1'b1);
  assign wr_ok = !i_ce_n && i_oe_n && !i_lockout;
  assign cmd = {a_l[14:0], i_dq};
  // Status only inside a busy sector; elsewhere array data, so a host polling outside ends at once on 8'hff or fails on the limit flag of 8'h3c
  assign val = (st != F_RD && sel[i_addr[16:14]]) ? {1'b0, tog, st == F_FAIL, st >= F_ERS, st != F_WIN, 3'b000}
    : (o_erased[i_addr[16:14]] ? 8'hff : 8'h3c);
  // Released bus shows the inverse of the last byte, never a kind constant
  assign o_dq = (!i_ce_n && !i_oe_n) ? val : ~last;
  always @(posedge i_clk_sys) begin
    wep <= i_we_n;
    oep <= i_oe_n;
    if (!i_ce_n && !i_oe_n) last <= val;
    if (oep && !i_oe_n && !i_ce_n && st != F_RD) tog <= ~tog;
    if (st != F_RD && st != F_FAIL) cnt <= cnt + 1;
    if (wr_ok && wep && !i_we_n) begin
      a_l <= i_addr;
      if (st == F_WIN) cnt <= 0;
    end
    if (st == F_WIN && cnt >= WIN) begin
      st <= F_PRG;
      cnt <= 0;
    end
    if (st == F_PRG && cnt >= PRG) begin
      st <= F_ERS;
      cnt <= 0;
    end
    if (st == F_ERS && cnt >= ERS) begin
      st <= i_fail ? F_FAIL : F_RD;
      if (!i_fail) o_erased <= o_erased | sel;
    end
    if (wr_ok && !wep && i_we_n && pu_inh) pu_inh <= 1'b0;
    else if (wr_ok && !wep && i_we_n) begin
      step <= 3'h0;
      if (st == F_WIN) begin
        if (i_dq == CODE_SECT) sel[a_l[16:14]] <= 1'b1;
        else st <= F_RD;
      end else if (st == F_RD || st == F_FAIL) begin
        case (step)
          3'h0: if (cmd == {ADDR_UNLOCK1[14:0], CODE_UNLOCK1}) step <= 3'h1;
          3'h1: if (cmd == {ADDR_UNLOCK2[14:0], CODE_UNLOCK2}) step <= 3'h2;
          3'h2: if (cmd == {ADDR_UNLOCK1[14:0], CODE_SETUP}) step <= 3'h3;
            else if (cmd == {ADDR_UNLOCK1[14:0], CODE_RESET}) st <= F_RD;
          3'h3: if (cmd == {ADDR_UNLOCK1[14:0], CODE_UNLOCK1}) step <= 3'h4;
          3'h4: if (cmd == {ADDR_UNLOCK2[14:0], CODE_UNLOCK2}) step <= 3'h5;
          default: if (st == F_RD) begin
            cnt <= 0;
            if (cmd == {ADDR_UNLOCK1[14:0], CODE_CHIP}) begin
              sel <= 8'hff;
              st <= F_PRG;
            end else if (i_dq == CODE_SECT) begin
              sel <= 8'h01 << a_l[16:14];
              st <= F_WIN;
            end
          end
        endcase
      end
    end
    if (i_lockout) begin
      st <= F_RD;
      step <= 3'h0;
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the erase sequencer controller
`timescale 1ns/10ps
`default_nettype none
module tb import hfc_pkg::*; ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, lockout = 1'b0, fail = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ce_n, oe_n, we_n, cdq_oe;
  logic wep = 1'b1;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [16:0] faddr;
  logic [7:0] cdq, mdq, fdq, erased;
  logic [24:0] wq[$], eq[$];
  int bad_count = 0;
  int checks_done = 0;

  always #5 clk = ~clk;
  assign fdq = cdq_oe ? cdq : mdq;

  hfc_erase_ctrl hfc_erase_ctrl_i (.i_clk_sys(clk), .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'h1), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_lockout(lockout),
    .o_flash_ce_n(ce_n), .o_flash_oe_n(oe_n), .o_flash_we_n(we_n), .o_flash_addr(faddr), .o_flash_dq(cdq),
    .o_flash_dq_oe(cdq_oe), .i_flash_dq(fdq));
  hfc_flash_model hfc_flash_model_i (.i_clk_sys(clk), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
    .i_addr(faddr), .i_dq(fdq), .i_lockout(lockout), .i_fail(fail), .o_dq(mdq), .o_erased(erased));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Sampled at the falling edge so the strobe outputs have settled
  always @(negedge clk) begin
    wep <= we_n;
    if (!wep && we_n && !ce_n) wq.push_back({faddr, fdq});
    if (!we_n) chk({31'h0, oe_n && !ce_n}, 32'h1);
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah, wh, bh;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid && bready;
      r = bresp;
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end while (!bh);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, rh;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ah = arvalid && arready;
      rh = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ah) arvalid <= 1'b0;
    end while (!rh);
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk(32'(r), 32'(RESP_OKAY));
  endtask

  task automatic wait_end(output logic [31:0] d);
    logic [1:0] r;
    do axi_rd(REG_STAT, d, r);
    while (d[ST_BUSY] !== 1'b0 || (d[ST_DONE] !== 1'b1 && d[ST_FAIL] !== 1'b1));
  endtask

  task automatic push3(input logic [16:0] a, input logic [7:0] c);
    eq.push_back({ADDR_UNLOCK1, CODE_UNLOCK1});
    eq.push_back({ADDR_UNLOCK2, CODE_UNLOCK2});
    eq.push_back({a, c});
  endtask

  task automatic sect_exp(input logic [7:0] m);
    push3(ADDR_UNLOCK1, CODE_SETUP);
    eq.push_back({ADDR_UNLOCK1, CODE_UNLOCK1});
    eq.push_back({ADDR_UNLOCK2, CODE_UNLOCK2});
    for (int i = 0; i < 8; i++)
      if (m[i]) eq.push_back({3'(i), 14'h0, CODE_SECT});
  endtask

  task automatic chk_cmds;
    chk(32'(wq.size()), 32'(eq.size()));
    foreach (eq[i]) chk(32'(wq[i]), 32'(eq[i]));
    wq.delete();
    eq.delete();
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    chk({29'h0, ce_n, oe_n, we_n}, 32'h7);
    axi_rd(REG_STAT, d, r);
    chk(d, 32'h0);
    wr(REG_SECT, 32'ha5);
    axi_rd(REG_SECT, d, r);
    chk(d, 32'ha5);
    axi_wr(8'h0c, 32'h1, r);
    chk(32'(r), 32'(RESP_SLVERR));
    axi_rd(8'h0c, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    chk(32'(wq.size()), 32'h0);
    $display("test registers done");
  endtask

  task automatic t_sect;
    logic [31:0] d;
    wr(REG_CTRL, 32'h1 << CTRL_SECT);
    wr(REG_CTRL, 32'h1 << CTRL_CHIP);
    sect_exp(8'ha5);
    wait_end(d);
    chk(d, 32'hff02);
    chk_cmds;
    chk(32'(erased), 32'ha5);
    wr(REG_STAT, 32'h6);
    $display("test sector erase done");
  endtask

  task automatic t_fail;
    logic [31:0] d;
    fail <= 1'b1;
    wr(REG_SECT, 32'h2);
    wr(REG_CTRL, 32'h1 << CTRL_SECT);
    sect_exp(8'h02);
    push3(ADDR_UNLOCK1, CODE_RESET);
    wait_end(d);
    chk(32'(d[2:0]), 32'h4);
    chk(32'(d[15:8] & 8'hbf), 32'h38);
    chk_cmds;
    chk(32'(erased), 32'ha5);
    fail <= 1'b0;
    wr(REG_STAT, 32'h6);
    $display("test time limit done");
  endtask

  task automatic t_lock;
    logic [31:0] d;
    logic [1:0] r;
    wr(REG_CTRL, 32'h1 << CTRL_CHIP);
    repeat (20) @(posedge clk);
    lockout <= 1'b1;
    repeat (30) @(posedge clk);
    wr(REG_CTRL, 32'h1 << CTRL_CHIP);
    repeat (30) @(posedge clk);
    axi_rd(REG_STAT, d, r);
    chk(32'(d[7:0]), 32'h8);
    chk(32'(erased), 32'ha5);
    lockout <= 1'b0;
    wq.delete();
    $display("test lockout done");
  endtask

  task automatic t_chip;
    logic [31:0] d;
    push3(ADDR_UNLOCK1, CODE_SETUP);
    push3(ADDR_UNLOCK1, CODE_CHIP);
    wr(REG_CTRL, 32'h1 << CTRL_CHIP);
    wait_end(d);
    chk(d, 32'hff02);
    chk_cmds;
    chk(32'(erased), 32'hff);
    wr(REG_STAT, 32'h6);
    push3(ADDR_UNLOCK1, CODE_RESET);
    wr(REG_CTRL, 32'h1 << CTRL_RST);
    wait_end(d);
    chk(32'(d[3:0]), 32'h2);
    chk_cmds;
    $display("test chip erase and reset done");
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_sect;
    t_fail;
    t_lock;
    t_chip;
    final_report;
  end

  // Two accumulation windows plus erase phases stay well below this
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    final_report;
  end
endmodule
`default_nettype wire
